// [tcu_pkg.sv]
// Shared constants and types for the 8-bit timer compare unit
package tcu_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CNT = 8'h04;
	localparam logic [7:0] ADDR_CMP = 8'h08;
	localparam logic [7:0] ADDR_ASYNC = 8'h0c;
	localparam logic [7:0] ADDR_FLAG = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;
	// Control register fields
	localparam int CTRL_CS_LSB = 0;
	localparam int CTRL_WGM_LO = 3;
	localparam int CTRL_COM_LSB = 4;
	localparam int CTRL_WGM_HI = 6;
	localparam int CTRL_FORCE = 7;
	// Async status, flag and mask fields
	localparam int ASYNC_SEL_BIT = 3;
	localparam int FLAG_CMP_BIT = 7;
	localparam int FLAG_OVF_BIT = 6;
	// Reset and extreme values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// Prescaler tap masks, divide by 1 up to 1024
	localparam logic [9:0] PRE_MASK_1 = 10'h000;
	localparam logic [9:0] PRE_MASK_8 = 10'h007;
	localparam logic [9:0] PRE_MASK_32 = 10'h01f;
	localparam logic [9:0] PRE_MASK_64 = 10'h03f;
	localparam logic [9:0] PRE_MASK_128 = 10'h07f;
	localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
	localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;
	typedef enum logic [1:0] {
		TCU_NORMAL = 2'b00,
		TCU_PWM_PHASE = 2'b01,
		TCU_CTC = 2'b10,
		TCU_PWM_FAST = 2'b11
	} tcu_mode_e;
	typedef enum logic [1:0] {
		TCU_COM_OFF = 2'b00,
		TCU_COM_TOGGLE = 2'b01,
		TCU_COM_CLEAR = 2'b10,
		TCU_COM_SET = 2'b11
	} tcu_com_e;
	typedef enum logic [2:0] {
		TCU_CS_STOP = 3'h0,
		TCU_CS_DIV1 = 3'h1,
		TCU_CS_DIV8 = 3'h2,
		TCU_CS_DIV32 = 3'h3,
		TCU_CS_DIV64 = 3'h4,
		TCU_CS_DIV128 = 3'h5,
		TCU_CS_DIV256 = 3'h6,
		TCU_CS_DIV1024 = 3'h7
	} tcu_cs_e;
endpackage : tcu_pkg

// [tcu_wave_if.sv]
// Signals between the counter core and the waveform generator
`timescale 1ns/100ps
interface tcu_wave_if;
	import tcu_pkg::*;
	tcu_mode_e mode;
	tcu_com_e com;
	logic match_ev;
	logic force_ev;
	logic wrap_ev;
	logic count_down;
	logic oc;
	modport core (output mode, output com, output match_ev, output force_ev, output wrap_ev,
		output count_down, input oc);
	modport wave (input mode, input com, input match_ev, input force_ev, input wrap_ev,
		input count_down, output oc);
endinterface : tcu_wave_if

// [tcu_prescaler.sv]
// Timer clock source select and prescaler, makes the timer clock enable
`timescale 1ns/100ps
module tcu_prescaler
	import tcu_pkg::*;
(
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire tcu_pkg::tcu_cs_e clock_select_field, // Prescaler select
	input wire logic async_clock_select, // Use crystal oscillator
	input wire logic crystal_pin_in, // Crystal oscillator input
	output logic timer_clock, // One-cycle timer clock enable
	output logic crystal_pin_out // Oscillator feedback drive
);
	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic base_tick;
	logic [9:0] pre_q;
	logic [9:0] tap;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			crystal_pin_out <= 1'b0;
		end else begin
			sync1_q <= crystal_pin_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			crystal_pin_out <= ~sync2_q;
		end
	end

	assign base_tick = async_clock_select ? (sync2_q & ~sync3_q) : 1'b1;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_q <= 10'h000;
		end else if (base_tick) begin
			pre_q <= pre_q + 10'h001;
		end
	end

	always_comb begin
		case (clock_select_field)
			TCU_CS_DIV1: tap = PRE_MASK_1;
			TCU_CS_DIV8: tap = PRE_MASK_8;
			TCU_CS_DIV32: tap = PRE_MASK_32;
			TCU_CS_DIV64: tap = PRE_MASK_64;
			TCU_CS_DIV128: tap = PRE_MASK_128;
			TCU_CS_DIV256: tap = PRE_MASK_256;
			TCU_CS_DIV1024: tap = PRE_MASK_1024;
			default: tap = PRE_MASK_1;
		endcase
	end

	assign timer_clock = base_tick && (clock_select_field != TCU_CS_STOP) && ((pre_q & tap) == tap);
endmodule : tcu_prescaler

// [tcu_wave.sv]
// Waveform generator driving the compare output state
`timescale 1ns/100ps
module tcu_wave
	import tcu_pkg::*;
(
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	tcu_wave_if.wave wv // Core side signals
);
	logic oc_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			oc_q <= 1'b0;
		end else begin
			case (wv.mode)
				TCU_NORMAL, TCU_CTC: begin
					if (wv.match_ev || wv.force_ev) begin
						case (wv.com)
							TCU_COM_TOGGLE: oc_q <= ~oc_q;
							TCU_COM_CLEAR: oc_q <= 1'b0;
							TCU_COM_SET: oc_q <= 1'b1;
							default: oc_q <= oc_q;
						endcase
					end
				end
				TCU_PWM_FAST: begin
					if (wv.match_ev && wv.com[1]) begin
						oc_q <= wv.com[0];
					end else if (wv.wrap_ev && wv.com[1]) begin
						oc_q <= ~wv.com[0];
					end
				end
				TCU_PWM_PHASE: begin
					if (wv.match_ev && wv.com[1]) begin
						oc_q <= wv.com[0] ^ wv.count_down;
					end
				end
				default: oc_q <= oc_q;
			endcase
		end
	end

	assign wv.oc = oc_q;
endmodule : tcu_wave

// [tcu_top.sv]
// 8-bit timer with one compare channel behind an AHB-Lite slave
//
// Notes on behaviour
// - Counter and compare are 8-bit, read/write
// - Timer clock from io clock or crystal
// - Clock select zero stops the counter
// - Each tick clears, increments or decrements
// - Counter accessible with or without clock
// - Host counter write beats count/clear
// - Two mode bits choose count sequence
// - Overflow flag per mode, raises request if enabled
// - Comparator flags counter equals compare
// - Compare flag set on following tick
// - Enabled compare flag raises request
// - Flag clears on service or write-one
// - Output from match, mode, output mode
// - Max and count direction feed waveform generator
// - Compare double buffered in PWM only
// - Buffer loads at top (0xFF) only
// - Host reaches buffer or active compare
// - Bottom at 0x00, max at 0xFF
// - Top is 0xFF or compare value
// - Requests in flag reg, masked individually
// - Force strobe updates output only
// - Counter write blocks next tick's match
// - Mode 0 wraps, mode 2 clears
`timescale 1ns/100ps
module tcu_top
	import tcu_pkg::*;
(
	input wire logic hclk, // Bus and io clock
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size, word only
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready in
	output logic hreadyout, // Always ready
	output logic hresp, // Always OKAY
	output logic [31:0] hrdata, // Read data, registered
	input wire logic crystal_pin_in, // Watch crystal input
	output logic crystal_pin_out, // Watch crystal drive
	output logic compare_output_pin, // Compare output state
	output logic compare_output_en, // Port override enable
	input wire logic compare_irq_ack, // Compare request serviced
	input wire logic overflow_irq_ack, // Overflow request serviced
	output logic compare_irq, // Compare interrupt request
	output logic overflow_irq // Overflow interrupt request
);
	import tcu_pkg::*;

	tcu_wave_if wv ();

	logic [7:0] ctrl_q;
	logic [7:0] counter_value_q;
	logic [7:0] compare_value_q;
	logic [7:0] compare_buf_q;
	logic async_clock_select_q;
	logic compare_flag_q;
	logic overflow_flag_q;
	logic compare_irq_enable_q;
	logic overflow_irq_enable_q;
	logic count_down_q;
	logic block_q;
	logic force_q;
	logic wr_q;
	logic [7:0] waddr_q;
	logic [31:0] rdata_d;
	logic addr_ok;
	logic [7:0] wbyte;
	logic wr_ctrl;
	logic wr_cnt;
	logic wr_cmp;
	logic wr_async;
	logic wr_flag;
	logic wr_mask;
	logic timer_clock;
	logic adv;
	logic match;
	logic match_ok;
	logic cnt_is_max;
	logic cnt_is_bottom;
	logic ovf_ev;
	logic dbuf_on;
	tcu_mode_e mode;
	tcu_com_e com;
	tcu_cs_e clock_select_field;

	assign mode = tcu_mode_e'({ctrl_q[CTRL_WGM_HI], ctrl_q[CTRL_WGM_LO]});
	assign com = tcu_com_e'(ctrl_q[CTRL_COM_LSB +: 2]);
	assign clock_select_field = tcu_cs_e'(ctrl_q[CTRL_CS_LSB +: 3]);

	// Bus slave: zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			waddr_q <= BYTE_RST;
		end else begin
			wr_q <= addr_ok && hwrite;
			waddr_q <= haddr[7:0];
		end
	end

	assign wbyte = hwdata[7:0];
	assign wr_ctrl = wr_q && (waddr_q == ADDR_CTRL);
	assign wr_cnt = wr_q && (waddr_q == ADDR_CNT);
	assign wr_cmp = wr_q && (waddr_q == ADDR_CMP);
	assign wr_async = wr_q && (waddr_q == ADDR_ASYNC);
	assign wr_flag = wr_q && (waddr_q == ADDR_FLAG);
	assign wr_mask = wr_q && (waddr_q == ADDR_MASK);

	assign dbuf_on = (mode == TCU_PWM_PHASE) || (mode == TCU_PWM_FAST);

	always_comb begin
		rdata_d = WORD_ZERO;
		case (haddr[7:0])
			ADDR_CTRL: rdata_d[7:0] = {1'b0, ctrl_q[6:0]};
			ADDR_CNT: rdata_d[7:0] = counter_value_q;
			ADDR_CMP: rdata_d[7:0] = dbuf_on ? compare_buf_q : compare_value_q;
			ADDR_ASYNC: rdata_d[ASYNC_SEL_BIT] = async_clock_select_q;
			ADDR_FLAG: begin
				rdata_d[FLAG_CMP_BIT] = compare_flag_q;
				rdata_d[FLAG_OVF_BIT] = overflow_flag_q;
			end
			ADDR_MASK: begin
				rdata_d[FLAG_CMP_BIT] = compare_irq_enable_q;
				rdata_d[FLAG_OVF_BIT] = overflow_irq_enable_q;
			end
			default: rdata_d = WORD_ZERO;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= WORD_ZERO;
		end else if (addr_ok && !hwrite) begin
			hrdata <= rdata_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= BYTE_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= {1'b0, wbyte[6:0]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			force_q <= 1'b0;
		end else begin
			force_q <= wr_ctrl && wbyte[CTRL_FORCE] && !(wbyte[CTRL_WGM_LO]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			async_clock_select_q <= 1'b0;
		end else if (wr_async) begin
			async_clock_select_q <= wbyte[ASYNC_SEL_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_irq_enable_q <= 1'b0;
			overflow_irq_enable_q <= 1'b0;
		end else if (wr_mask) begin
			compare_irq_enable_q <= wbyte[FLAG_CMP_BIT];
			overflow_irq_enable_q <= wbyte[FLAG_OVF_BIT];
		end
	end

	tcu_prescaler u_prescaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.clock_select_field(clock_select_field),
		.async_clock_select(async_clock_select_q),
		.crystal_pin_in(crystal_pin_in),
		.timer_clock(timer_clock),
		.crystal_pin_out(crystal_pin_out)
	);

	assign adv = timer_clock && !wr_cnt;

	assign match = (counter_value_q == compare_value_q);
	assign cnt_is_max = (counter_value_q == CNT_MAX);
	assign cnt_is_bottom = (counter_value_q == CNT_BOTTOM);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			block_q <= 1'b0;
		end else if (wr_cnt) begin
			block_q <= 1'b1;
		end else if (timer_clock) begin
			block_q <= 1'b0;
		end
	end

	assign match_ok = adv && match && !block_q;

	// clear, up or down per tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter_value_q <= BYTE_RST;
			count_down_q <= 1'b0;
		end else if (wr_cnt) begin
			counter_value_q <= wbyte;
		end else if (adv) begin
			case (mode)
				TCU_CTC: begin
					if (match && !block_q) begin
						counter_value_q <= CNT_BOTTOM;
					end else begin
						counter_value_q <= counter_value_q + CNT_ONE;
					end
					count_down_q <= 1'b0;
				end
				TCU_PWM_PHASE: begin
					if (!count_down_q && cnt_is_max) begin
						count_down_q <= 1'b1;
						counter_value_q <= counter_value_q - CNT_ONE;
					end else if (count_down_q && cnt_is_bottom) begin
						count_down_q <= 1'b0;
						counter_value_q <= counter_value_q + CNT_ONE;
					end else if (count_down_q) begin
						counter_value_q <= counter_value_q - CNT_ONE;
					end else begin
						counter_value_q <= counter_value_q + CNT_ONE;
					end
				end
				default: begin
					counter_value_q <= counter_value_q + CNT_ONE;
					count_down_q <= 1'b0;
				end
			endcase
		end
	end

	always_comb begin
		case (mode)
			TCU_PWM_PHASE: ovf_ev = adv && count_down_q && (counter_value_q == CNT_ONE);
			default: ovf_ev = adv && cnt_is_max;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_flag_q <= 1'b0;
		end else if (match_ok) begin
			compare_flag_q <= 1'b1;
		end else if (compare_irq_ack || (wr_flag && wbyte[FLAG_CMP_BIT])) begin
			compare_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overflow_flag_q <= 1'b0;
		end else if (ovf_ev) begin
			overflow_flag_q <= 1'b1;
		end else if (overflow_irq_ack || (wr_flag && wbyte[FLAG_OVF_BIT])) begin
			overflow_flag_q <= 1'b0;
		end
	end

	assign compare_irq = compare_flag_q && compare_irq_enable_q;
	assign overflow_irq = overflow_flag_q && overflow_irq_enable_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_buf_q <= BYTE_RST;
		end else if (wr_cmp) begin
			compare_buf_q <= wbyte;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_value_q <= BYTE_RST;
		end else if (!dbuf_on) begin
			if (wr_cmp) begin
				compare_value_q <= wbyte;
			end
		end else if (adv && cnt_is_max && !(mode == TCU_PWM_PHASE && count_down_q)) begin
			compare_value_q <= compare_buf_q;
		end
	end

	assign wv.mode = mode;
	assign wv.com = com;
	assign wv.match_ev = match_ok;
	assign wv.force_ev = force_q;
	assign wv.wrap_ev = adv && cnt_is_max;
	assign wv.count_down = count_down_q;

	tcu_wave u_wave (
		.hclk(hclk),
		.hresetn(hresetn),
		.wv(wv)
	);

	assign compare_output_pin = wv.oc;
	assign compare_output_en = (com != TCU_COM_OFF);
endmodule : tcu_top

// [tcu_checker.sv]
// Port-level assertions for the timer compare unit
`timescale 1ns/100ps
module tcu_checker
	import tcu_pkg::*;
(
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer
	input wire logic hwrite, // Write
	input wire logic hready, // Ready in
	input wire logic hreadyout, // Ready out
	input wire logic hresp, // Response
	input wire logic [31:0] hrdata, // Read data
	input wire logic compare_output_pin, // Output
	input wire logic compare_output_en, // Enable
	input wire logic compare_irq_ack, // Ack
	input wire logic overflow_irq_ack, // Ack
	input wire logic compare_irq, // Request
	input wire logic overflow_irq // Request
);
	logic acc;
	logic [2:0] wr_q;
	assign acc = hsel & htrans[1] & hready;
	// Data-phase writes to control, flag, mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 3'h0;
		end else begin
			wr_q <= {acc & hwrite & (haddr[7:0] == ADDR_CTRL), acc & hwrite & (haddr[7:0] == ADDR_FLAG),
				acc & hwrite & (haddr[7:0] == ADDR_MASK)};
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_READY: assert property (hreadyout) else $error("slave not ready");
	AST_RESP: assert property (!hresp) else $error("error response");
	AST_RST_QUIET: assert property ($rose(hresetn) |-> !compare_irq && !overflow_irq && !compare_output_pin)
		else $error("output active after reset");
	AST_OUT_EN: assert property ($changed(compare_output_en) |-> $past(wr_q[2]))
		else $error("output enable moved without control write");
	AST_CMP_FALL: assert property ($fell(compare_irq) |-> $past(compare_irq_ack) || $past(wr_q[1]) || $past(wr_q[0]))
		else $error("compare request dropped without cause");
	AST_OVF_FALL: assert property ($fell(overflow_irq) |-> $past(overflow_irq_ack) || $past(wr_q[1]) || $past(wr_q[0]))
		else $error("overflow request dropped without cause");
	AST_RDATA_UPPER: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
	AST_RDATA_HOLD: assert property (!(acc && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without read");
	COV_CMP: cover property ($rose(compare_irq));
	COV_OVF: cover property ($rose(overflow_irq));
	COV_PIN: cover property ($changed(compare_output_pin));
endmodule : tcu_checker

// [eight_bit_timer_compare_unit_test.sv]
// Self-checking bench for the timer compare unit
`timescale 1ns/100ps
module eight_bit_timer_compare_unit_test;
	import tcu_pkg::*;
	logic hclk, hresetn, hsel, hwrite, xtal, cmp_ack, ovf_ack;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic hreadyout, hresp, xout, pin, pin_en, cmp_irq, ovf_irq;
	logic [7:0] s;
	int err_count, n_compared, cyc, n;
	tcu_top u_tcu_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .crystal_pin_in(xtal), .crystal_pin_out(xout),
		.compare_output_pin(pin), .compare_output_en(pin_en), .compare_irq_ack(cmp_ack),
		.overflow_irq_ack(ovf_ack), .compare_irq(cmp_irq), .overflow_irq(ovf_irq));
	function automatic logic [7:0] flag_exp(input logic [7:0] start, input int k);
		return (int'(start) + k > 255) ? 8'h40 : 8'h00;
	endfunction : flag_exp
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : xfer
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		xfer(a, 1'b0, 32'h0);
		check($sformatf("register %h", a), rd, {24'h0, e});
	endtask : rchk
	// Crystal pulses, still between frames
	task automatic ticks(input int k);
		repeat (k) begin
			xtal <= 1'b1;
			repeat (4) @(posedge hclk);
			xtal <= 1'b0;
			repeat (4) @(posedge hclk);
		end
		repeat (6) @(posedge hclk);
	endtask : ticks
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		{hresetn, hsel, hwrite, xtal, cmp_ack, ovf_ack, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		err_count = 0;
		n_compared = 0;
		cyc = 0;
		s = 8'($urandom(65509));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		for (int a = 0; a < 28; a += 4) rchk(8'(a), 8'h00);
		xfer(8'h18, 1'b1, 32'hff);
		rchk(8'h18, 8'h00);
		repeat (6) begin
			s = 8'($urandom());
			xfer(ADDR_CNT, 1'b1, {24'h0, s});
			rchk(ADDR_CNT, s);
			xfer(ADDR_CMP, 1'b1, {24'h0, ~s});
			rchk(ADDR_CMP, ~s);
		end
		xfer(ADDR_ASYNC, 1'b1, 32'h8);
		rchk(ADDR_ASYNC, 8'h08);
		ticks(3);
		rchk(ADDR_CNT, s);
		check("crystal drive", xout, 32'h1);
		xfer(ADDR_CTRL, 1'b1, 32'h11);
		xfer(ADDR_MASK, 1'b1, 32'h40);
		xfer(ADDR_CMP, 1'b1, 32'h80);
		s = 8'hf0 + 8'($urandom_range(15));
		n = $urandom_range(16, 24);
		xfer(ADDR_CNT, 1'b1, {24'h0, s});
		ticks(n);
		rchk(ADDR_CNT, s + n[7:0]);
		rchk(ADDR_FLAG, flag_exp(s, n));
		check("overflow request", ovf_irq, 32'(flag_exp(s, n) >> 6));
		@(posedge hclk);
		ovf_ack <= 1'b1;
		@(posedge hclk);
		ovf_ack <= 1'b0;
		rchk(ADDR_FLAG, 8'h00);
		xfer(ADDR_MASK, 1'b1, 32'hc0);
		xfer(ADDR_CMP, 1'b1, 32'h10);
		xfer(ADDR_CNT, 1'b1, 32'h0e);
		ticks(2);
		rchk(ADDR_FLAG, 8'h00);
		check("output", pin, 32'h0);
		ticks(1);
		rchk(ADDR_FLAG, 8'h80);
		check("compare request", cmp_irq, 32'h1);
		check("output", pin, 32'h1);
		xfer(ADDR_FLAG, 1'b1, 32'h0);
		rchk(ADDR_FLAG, 8'h80);
		@(posedge hclk);
		cmp_ack <= 1'b1;
		@(posedge hclk);
		cmp_ack <= 1'b0;
		rchk(ADDR_FLAG, 8'h00);
		check("compare request", cmp_irq, 32'h0);
		xfer(ADDR_CNT, 1'b1, 32'h10);
		ticks(1);
		rchk(ADDR_FLAG, 8'h00);
		check("output", pin, 32'h1);
		xfer(ADDR_CTRL, 1'b1, 32'h91);
		rchk(ADDR_FLAG, 8'h00);
		rchk(ADDR_CNT, 8'h11);
		check("output", pin, 32'h0);
		check("output enable", pin_en, 32'h1);
		rchk(ADDR_CTRL, 8'h11);
		xfer(ADDR_CTRL, 1'b1, 32'hb1);
		rchk(ADDR_CTRL, 8'h31);
		check("output", pin, 32'h1);
		xfer(ADDR_CTRL, 1'b1, 32'ha1);
		rchk(ADDR_CTRL, 8'h21);
		check("output", pin, 32'h0);
		xfer(ADDR_CTRL, 1'b1, 32'h41);
		xfer(ADDR_CMP, 1'b1, 32'h05);
		xfer(ADDR_CNT, 1'b1, 32'h00);
		ticks(7);
		rchk(ADDR_CNT, 8'h01);
		rchk(ADDR_FLAG, 8'h80);
		check("output enable", pin_en, 32'h0);
		xfer(ADDR_FLAG, 1'b1, 32'h80);
		xfer(ADDR_CTRL, 1'b1, 32'h01);
		xfer(ADDR_CMP, 1'b1, 32'h30);
		xfer(ADDR_CTRL, 1'b1, 32'h69);
		xfer(ADDR_CMP, 1'b1, 32'h40);
		rchk(ADDR_CMP, 8'h40);
		xfer(ADDR_CNT, 1'b1, 32'h3e);
		ticks(4);
		rchk(ADDR_FLAG, 8'h00);
		xfer(ADDR_CNT, 1'b1, 32'hfe);
		ticks(2);
		rchk(ADDR_FLAG, 8'h40);
		check("output", pin, 32'h1);
		xfer(ADDR_FLAG, 1'b1, 32'h40);
		xfer(ADDR_CNT, 1'b1, 32'h3e);
		ticks(3);
		rchk(ADDR_FLAG, 8'h80);
		check("output", pin, 32'h0);
		xfer(ADDR_CTRL, 1'b1, 32'h09);
		xfer(ADDR_CNT, 1'b1, 32'hfe);
		ticks(3);
		rchk(ADDR_CNT, 8'hfd);
		close_out();
	end
endmodule : eight_bit_timer_compare_unit_test
bind tcu_top tcu_checker u_tcu_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .compare_output_pin(compare_output_pin), .compare_output_en(compare_output_en),
	.compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack), .compare_irq(compare_irq),
	.overflow_irq(overflow_irq));
